// >>> vlod_pkg.sv
// shared constants, types and translation tables of the op decoder
`default_nettype none

package vlod_pkg;

	// ****************************************
	// sizes and limits
	// ****************************************
	localparam int         LINE_BYTES      = 16;
	localparam int         LINE_OPS        = 4;
	localparam logic [3:0] MIN_INSN_LEN    = 4'h1;
	localparam logic [3:0] MAX_INSN_LEN    = 4'hf;
	localparam logic [3:0] SHORT_MAX_LEN   = 4'h7;
	localparam logic [3:0] LONG_MAX_LEN    = 4'hb;
	localparam logic [2:0] SHORT_MAX_OPS   = 3'h2;
	localparam logic [2:0] LONG_MAX_OPS    = 3'h4;
	localparam logic [2:0] VEC_FIRST_OPS   = 3'h4;
	localparam logic [5:0] LINE_END        = 6'h10;
	localparam logic [3:0] LAST_BYTE_IDX   = 4'hf;
	localparam logic [4:0] PTR_RESET       = 5'h00;
	localparam logic [3:0] REMAIN_RESET    = 4'h0;
	localparam logic [2:0] ROM_ADDR_RESET  = 3'h0;

	// ****************************************
	// instruction classes, low nibble of the first byte
	// ****************************************
	localparam logic [3:0] CLS_ADD      = 4'h0;
	localparam logic [3:0] CLS_LOAD     = 4'h1;
	localparam logic [3:0] CLS_STORE    = 4'h2;
	localparam logic [3:0] CLS_CMPM     = 4'h3;
	localparam logic [3:0] CLS_LDIMM    = 4'h4;
	localparam logic [3:0] CLS_MEDIA    = 4'h5;
	localparam logic [3:0] CLS_FLOAT    = 4'h6;
	localparam logic [3:0] CLS_BRANCH   = 4'h7;
	localparam logic [3:0] CLS_RMW      = 4'h8;
	localparam logic [3:0] CLS_RMWB     = 4'h9;
	localparam logic [3:0] CLS_VEC_BASE = 4'ha;

	// op category; each names its unit class
	typedef enum logic [2:0] {
		CAT_LOAD,   // load unit
		CAT_LDIMM,  // instruction_control_unit
		CAT_STORE,  // store unit
		CAT_INT,    // integer units
		CAT_MEDIA,  // multimedia unit
		CAT_FLOAT,  // floating-point unit
		CAT_BRANCH  // branch unit
	} vlod_cat_t;

	typedef enum logic [1:0] {KIND_SHORT, KIND_LONG, KIND_VECTOR} vlod_kind_t;

	typedef struct packed {
		vlod_cat_t  cat;
		logic       dualInt;
		logic       useLoad;
		logic [7:0] tag;
	} vlod_op_t;

	typedef struct packed {
		vlod_op_t [3:0] op;
		logic     [3:0] valid;
		vlod_kind_t     kind;
		logic           last;
	} vlod_line_t;

	typedef struct packed {
		vlod_op_t [3:0] op;
		logic     [2:0] cnt;
	} vlod_grp_t;

	// ****************************************
	// translation helpers
	// ****************************************
	function automatic vlod_op_t mkOp(vlod_cat_t c, logic d, logic u,
		logic [7:0] t);
		vlod_op_t o;
		o.cat     = c;
		o.dualInt = d;
		o.useLoad = u;
		o.tag     = t;
		return o;
	endfunction

	// a field of zero still means one byte so every start is 1..15
	function automatic logic [3:0] lenOf(logic [7:0] b);
		return (b[7:4] == 4'h0) ? MIN_INSN_LEN : b[7:4];
	endfunction

	function automatic vlod_grp_t translate(logic [3:0] cls, logic [7:0] t);
		vlod_grp_t g;
		g.cnt = 3'h1;
		for (int i = 0; i < LINE_OPS; i++) begin
			g.op[i] = mkOp(CAT_INT, 1'b0, 1'b0, t);
		end
		case (cls)
			CLS_ADD:    g.op[0] = mkOp(CAT_INT, 1'b1, 1'b0, t);
			CLS_LOAD:   g.op[0] = mkOp(CAT_LOAD, 1'b0, 1'b0, t);
			CLS_STORE:  g.op[0] = mkOp(CAT_STORE, 1'b0, 1'b0, t);
			CLS_LDIMM:  g.op[0] = mkOp(CAT_LDIMM, 1'b0, 1'b0, t);
			CLS_MEDIA:  g.op[0] = mkOp(CAT_MEDIA, 1'b0, 1'b0, t);
			CLS_FLOAT:  g.op[0] = mkOp(CAT_FLOAT, 1'b0, 1'b0, t);
			CLS_BRANCH: g.op[0] = mkOp(CAT_BRANCH, 1'b0, 1'b0, t);
			CLS_CMPM: begin
				g.op[0] = mkOp(CAT_LOAD, 1'b0, 1'b0, t);
				g.op[1] = mkOp(CAT_INT, 1'b1, 1'b1, t);
				g.cnt   = SHORT_MAX_OPS;
			end
			CLS_RMW: begin
				g.op[0] = mkOp(CAT_LOAD, 1'b0, 1'b0, t);
				g.op[1] = mkOp(CAT_INT, 1'b1, 1'b1, t);
				g.op[2] = mkOp(CAT_STORE, 1'b0, 1'b0, t);
				g.cnt   = 3'h3;
			end
			CLS_RMWB: begin
				g.op[0] = mkOp(CAT_LOAD, 1'b0, 1'b0, t);
				g.op[1] = mkOp(CAT_INT, 1'b1, 1'b1, t);
				g.op[2] = mkOp(CAT_STORE, 1'b0, 1'b0, t);
				g.op[3] = mkOp(CAT_BRANCH, 1'b0, 1'b0, t);
				g.cnt   = LONG_MAX_OPS;
			end
			default: begin
				g.op[0] = mkOp(CAT_LOAD, 1'b0, 1'b0, t);
				g.op[1] = mkOp(CAT_INT, 1'b1, 1'b1, t);
				g.op[2] = mkOp(CAT_INT, 1'b1, 1'b0, t);
				g.op[3] = mkOp(CAT_STORE, 1'b0, 1'b0, t);
				g.cnt   = VEC_FIRST_OPS;
			end
		endcase
		return g;
	endfunction

	// microcode sequence store, four ops per line
	function automatic vlod_line_t romLine(logic [2:0] a, logic [7:0] t);
		vlod_line_t l;
		l.valid = 4'hf;
		l.kind  = KIND_VECTOR;
		l.last  = 1'b0;
		if (a[0]) begin
			l.op[0] = mkOp(CAT_MEDIA, 1'b0, 1'b0, t);
			l.op[1] = mkOp(CAT_FLOAT, 1'b0, 1'b0, t);
			l.op[2] = mkOp(CAT_INT, 1'b1, 1'b0, t);
			l.op[3] = mkOp(CAT_BRANCH, 1'b0, 1'b0, t);
		end else begin
			l.op[0] = mkOp(CAT_INT, 1'b1, 1'b0, t);
			l.op[1] = mkOp(CAT_INT, 1'b1, 1'b0, t);
			l.op[2] = mkOp(CAT_LOAD, 1'b0, 1'b0, t);
			l.op[3] = mkOp(CAT_STORE, 1'b0, 1'b0, t);
		end
		return l;
	endfunction

endpackage

`default_nettype wire

// >>> vlod_buf.sv
// two-entry buffer between the decoder and the scheduler line port
`timescale 1ns/1ps
`default_nettype none

module vlod_buf import vlod_pkg::*; (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       inValid,
	output logic            inReady,
	input  wire vlod_line_t inData,
	output logic            outValid,
	input  wire logic       outReady,
	output vlod_line_t      outData
);

	logic       skidValid;
	vlod_line_t skidData;
	logic       headFree;

	assign headFree = outReady || !outValid;
	assign inReady  = !skidValid;

	always_ff @(posedge clk) begin
		if (rst) begin
			outValid  <= 1'b0;
			skidValid <= 1'b0;
		end else if (headFree) begin
			outValid  <= skidValid || inValid;
			skidValid <= 1'b0;
		end else if (inValid && inReady) begin
			skidValid <= 1'b1;
		end
	end

	// data flops carry no reset; validity is tracked separately
	always_ff @(posedge clk) begin
		if (headFree) begin
			outData <= skidValid ? skidData : inData;
		end else if (inValid && inReady) begin
			skidData <= inData;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	out_hold_a: assert property (
		outValid && !outReady |=> outValid && $stable(outData))
		else $error("line changed while scheduler stalled");
	no_loss_a: assert property (
		inValid && inReady && !headFree |=> skidValid && skidData == $past(inData))
		else $error("line lost on stall");
	stall_c: cover property (outValid && !outReady ##1 outValid && outReady);

endmodule

`default_nettype wire

// >>> vlod_decoder.sv
// variable-length instruction decoder: predecode, short/long/vector paths
`timescale 1ns/1ps
`default_nettype none

module vlod_decoder import vlod_pkg::*; (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       fillValid,
	input  wire logic [7:0] fillByte,
	output logic            fillReady,
	output logic            schedValid,
	input  wire logic       schedReady,
	output vlod_line_t      schedLine,
	output logic            vectorBusy
);

	typedef enum logic [1:0] {ST_FILL, ST_DECODE, ST_ROM} vlod_state_t;

	vlod_state_t state;
	vlod_state_t next_state;
	logic [7:0]  lineByte [LINE_BYTES];
	logic [3:0]  pdLen    [LINE_BYTES];
	logic [15:0] pdStart;
	logic [3:0]  fillIdx;
	logic [3:0]  fillRemain;
	logic [4:0]  ptr;
	logic [2:0]  romAddr;
	logic [2:0]  romCount;
	logic [7:0]  romTag;

	// ****************************************
	// decode selection
	// ****************************************
	logic        fillTake, emit, skipByte, pairOk, lineDone, bufInReady;
	logic [3:0]  idxA, idxB, lenA, lenB, clsA, clsB;
	logic [7:0]  tagA, tagB;
	logic [4:0]  ptrB, nextPtr;
	logic [5:0]  ptrC;
	vlod_kind_t  kindA, kindB;
	vlod_grp_t   grpA, grpB;
	vlod_line_t  decLine, romOut, pushLine;
	logic        pushValid, romLast, startByte;
	vlod_op_t    opArr  [LINE_OPS];
	logic        vldArr [LINE_OPS];

	assign fillTake = fillValid && fillReady;
	// each line starts afresh: a tail that ran past the last line is dropped
	assign startByte = fillRemain == REMAIN_RESET
		|| fillIdx == 4'h0;
	assign idxA     = ptr[3:0];
	assign lenA     = pdLen[idxA];
	assign clsA     = lineByte[idxA][3:0];
	assign tagA     = lineByte[4'(idxA + 4'h1)];
	// oversize non-vector encodings are pushed onto the vector path
	assign kindA = (clsA >= CLS_VEC_BASE || lenA > LONG_MAX_LEN)
		? KIND_VECTOR
		: (clsA >= CLS_RMW || lenA > SHORT_MAX_LEN) ? KIND_LONG
		: KIND_SHORT;
	assign grpA = translate(kindA == KIND_VECTOR ? CLS_VEC_BASE : clsA,
		tagA);
	assign ptrB = ptr + {1'b0, lenA};
	assign idxB = ptrB[3:0];
	assign lenB = pdLen[idxB];
	assign clsB = lineByte[idxB][3:0];
	assign tagB = lineByte[4'(idxB + 4'h1)];
	assign kindB = (clsB >= CLS_RMW || lenB > SHORT_MAX_LEN) ? KIND_LONG
		: KIND_SHORT;
	assign grpB = translate(clsB, tagB);
	assign ptrC = {1'b0, ptrB} + {2'b00, lenB};
	// second short needs its own predecode mark and must end in the line
	assign pairOk = kindA == KIND_SHORT && !ptrB[4] && pdStart[idxB]
		&& kindB == KIND_SHORT && ptrC <= LINE_END;
	assign emit     = state == ST_DECODE && pdStart[idxA]
		&& bufInReady;
	assign skipByte = state == ST_DECODE && !pdStart[idxA];
	assign nextPtr  = skipByte ? 5'(ptr + 5'h01)
		: (pairOk ? ptrC[4:0] : ptrB);
	assign lineDone = nextPtr[4];

	// lane i takes from the first group, then from the second
	for (genvar i = 0; i < LINE_OPS; i++) begin : g_lane
		logic [2:0] laneB;
		assign laneB = 3'(i) - grpA.cnt;
		assign vldArr[i] = 3'(i) < grpA.cnt
			|| (pairOk && 3'(i) >= grpA.cnt && laneB < grpB.cnt);
		assign opArr[i] = 3'(i) < grpA.cnt ? grpA.op[i]
			: grpB.op[laneB[1:0]];
	end

	always_comb begin
		decLine.kind = kindA;
		decLine.last = kindA != KIND_VECTOR;
		for (int i = 0; i < LINE_OPS; i++) begin
			decLine.op[i]    = opArr[i];
			decLine.valid[i] = vldArr[i];
		end
	end

	assign romLast = romAddr == 3'(romCount - 3'h1);
	always_comb begin
		romOut      = romLine(romAddr, romTag);
		romOut.last = romLast;
	end

	assign pushValid = emit || state == ST_ROM;
	assign pushLine  = state == ST_ROM ? romOut : decLine;

	// ****************************************
	// sequencing
	// ****************************************
	always_comb begin
		next_state = state;
		case (state)
			ST_FILL:
				if (fillTake && fillIdx == LAST_BYTE_IDX) next_state = ST_DECODE;
			ST_DECODE:
				if (emit && kindA == KIND_VECTOR) next_state = ST_ROM;
				else if ((emit || skipByte) && lineDone) next_state = ST_FILL;
			ST_ROM:
				if (bufInReady && romLast) begin
					next_state = ptr[4] ? ST_FILL : ST_DECODE;
				end
			default: next_state = ST_FILL;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state      <= ST_FILL;
			fillReady  <= 1'b1;
			vectorBusy <= 1'b0;
			pdStart    <= '0;
			fillIdx    <= 4'h0;
			fillRemain <= REMAIN_RESET;
			ptr        <= PTR_RESET;
			romAddr    <= ROM_ADDR_RESET;
			romCount   <= 3'h1;
			romTag     <= 8'h00;
		end else begin
			state      <= next_state;
			fillReady  <= next_state == ST_FILL;
			vectorBusy <= next_state == ST_ROM;
			if (fillTake) begin
				fillIdx <= 4'(fillIdx + 4'h1);
				if (startByte) begin
					pdStart[fillIdx] <= 1'b1;
					fillRemain       <= 4'(lenOf(fillByte) - 4'h1);
				end else begin
					fillRemain <= 4'(fillRemain - 4'h1);
				end
			end
			if (state != ST_FILL && next_state == ST_FILL) begin
				pdStart <= '0;
			end
			if (next_state == ST_DECODE && state == ST_FILL) begin
				ptr <= PTR_RESET;
			end else if (emit || skipByte) begin
				ptr <= nextPtr;
			end
			if (emit && kindA == KIND_VECTOR) begin
				romAddr  <= ROM_ADDR_RESET;
				romTag   <= tagA;
				romCount <= clsA >= CLS_VEC_BASE
					? 3'(clsA - CLS_VEC_BASE + 4'h1) : 3'h1;
			end else if (state == ST_ROM && bufInReady) begin
				romAddr <= 3'(romAddr + 3'h1);
			end
		end
	end

	// the predecode store is written without reset; pdStart guards it
	always_ff @(posedge clk) begin
		if (fillTake) begin
			lineByte[fillIdx] <= fillByte;
			if (startByte) pdLen[fillIdx] <= lenOf(fillByte);
		end
	end

	// back-pressure from the scheduler stops decode through inReady
	vlod_buf u_buf (
		.clk      (clk),
		.rst      (rst),
		.inValid  (pushValid),
		.inReady  (bufInReady),
		.inData   (pushLine),
		.outValid (schedValid),
		.outReady (schedReady),
		.outData  (schedLine)
	);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	pd_store_a: assert property (
		fillTake && startByte |=> pdStart[$past(fillIdx)]
		&& pdLen[$past(fillIdx)] == lenOf($past(fillByte)))
		else $error("predecode start not stored");
	pd_needed_a: assert property (
		emit |-> pdStart[idxA] && (!pairOk || pdStart[idxB]))
		else $error("decode without predecode mark");
	len_range_a: assert property (
		emit |-> lenA >= MIN_INSN_LEN && lenA <= MAX_INSN_LEN)
		else $error("instruction length out of range");
	pair_kind_a: assert property (
		emit && pairOk |-> kindA == KIND_SHORT && kindB == KIND_SHORT)
		else $error("pair with a non-short decode");
	short_size_a: assert property (
		emit && kindA == KIND_SHORT |-> lenA <= SHORT_MAX_LEN
		&& grpA.cnt >= 3'h1 && grpA.cnt <= SHORT_MAX_OPS)
		else $error("short decode out of bounds");
	long_size_a: assert property (
		emit && kindA == KIND_LONG |-> lenA <= LONG_MAX_LEN
		&& grpA.cnt <= LONG_MAX_OPS)
		else $error("long decode out of bounds");
	no_rom_a: assert property (
		emit && kindA != KIND_VECTOR |=> !vectorBusy && $stable(romAddr))
		else $error("short or long decode touched the rom");
	vec_start_a: assert property (
		emit && kindA == KIND_VECTOR |-> decLine.valid == 4'hf
		##1 vectorBusy && romAddr == ROM_ADDR_RESET)
		else $error("vector decode did not start rom");
	rom_rate_a: assert property (
		state == ST_ROM && bufInReady |-> pushValid && pushLine.valid == 4'hf
		##1 romAddr == 3'($past(romAddr) + 3'h1) || state != ST_ROM)
		else $error("rom not four ops per clock");
	cmp_split_a: assert property (
		emit && clsA == CLS_CMPM && kindA == KIND_SHORT
		|-> decLine.op[0].cat == CAT_LOAD && decLine.op[1].cat == CAT_INT
		&& decLine.op[1].useLoad)
		else $error("compare not split into load and compare");
	add_dual_a: assert property (
		emit && clsA == CLS_ADD && kindA == KIND_SHORT
		|-> decLine.op[0].cat == CAT_INT && decLine.op[0].dualInt)
		else $error("add not eligible for both integer units");
	rom_block_a: assert property (
		state == ST_ROM |=> ptr == $past(ptr))
		else $error("decode advanced during rom sequence");
	stall_hold_a: assert property (
		state == ST_DECODE && pdStart[idxA] && !bufInReady |=> $stable(ptr))
		else $error("decode advanced while stalled");

	pair_c: cover property (emit && pairOk);
	vec_long_c: cover property (emit && kindA == KIND_VECTOR
		##1 vectorBusy [*2]);
	long_c: cover property (emit && kindA == KIND_LONG);

endmodule

`default_nettype wire

// >>> vlod_sched_model.sv
// scheduler buffer model seen from the decoder's line port
`timescale 1ns/1ps
`default_nettype none

module vlod_sched_model import vlod_pkg::*; (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       lineValid,
	input  wire logic [3:0] laneMask,
	input  wire logic [1:0] mode,
	output logic            ready
);
	// ****************************************
	// occupancy
	// ****************************************
	logic [5:0] inOps;
	logic [5:0] sum;
	logic [2:0] drain;
	logic [4:0] held;
	logic [4:0] next_held;
	logic       tick;

	// one line of at most four ops enters per clock
	assign inOps = (lineValid & ready) ? 6'($countones(laneMask)) : 6'h00;
	// mode 0 drains fast, mode 1 one op every other clock, mode 2 freezes
	assign drain = (mode == 2'h0) ? 3'h4 : {2'h0, (mode == 2'h1) & tick};
	assign sum = 6'(held) + inOps;
	assign next_held = (sum > 6'(drain)) ? 5'(sum - 6'(drain)) : 5'h00;

	always_ff @(posedge clk) begin
		if (rst) begin
			held  <= 5'h00;
			tick  <= 1'b0;
			ready <= 1'b0;
		end else begin
			held  <= next_held;
			tick  <= ~tick;
			// room for a whole line keeps the store at 24 ops or fewer
			ready <= (mode != 2'h2) && (next_held <= 5'h14);
		end
	end
endmodule

`default_nettype wire

// >>> variable_length_op_decoder_tb.sv
// self-checking bench of the op decoder against a scheduler model
`timescale 1ns/1ps
`default_nettype none

module variable_length_op_decoder_tb import vlod_pkg::*;;
	logic       clk;
	logic       rst;
	logic       fillValid;
	logic [7:0] fillByte;
	logic       fillReady;
	logic       schedValid;
	logic       schedReady;
	vlod_line_t schedLine;
	logic       vectorBusy;
	logic [1:0] mode;
	int         failCount;
	int         nCompared;
	vlod_line_t expQ [$];
	logic [7:0] ins [$];
	logic [7:0] lineBuf [16];
	logic       stalled;
	vlod_line_t heldLine;
	// start bytes {length, class}, a zero closes each 16-byte line
	logic [7:0] fixedIns [29] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24,
		8'h25, 8'h26, 8'h27, 8'h00, 8'h73, 8'h70, 8'h21, 8'h00,
		8'hb0, 8'h58, 8'h00, 8'h89, 8'h87, 8'h00, 8'hca, 8'h4f, 8'h00,
		8'hfa, 8'h12, 8'h00, 8'h11, 8'h16, 8'hed, 8'h00};

	vlod_decoder i_vlod_decoder (
		.clk        (clk),
		.rst        (rst),
		.fillValid  (fillValid),
		.fillByte   (fillByte),
		.fillReady  (fillReady),
		.schedValid (schedValid),
		.schedReady (schedReady),
		.schedLine  (schedLine),
		.vectorBusy (vectorBusy)
	);

	vlod_sched_model i_vlod_sched_model (
		.clk       (clk),
		.rst       (rst),
		.lineValid (schedValid),
		.laneMask  (schedLine.valid),
		.mode      (mode),
		.ready     (schedReady)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ****************************************
	// reporting
	// ****************************************
	task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
		nCompared++;
		if (seen !== exp) begin
			failCount++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("compared %0d mismatches %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic giveUp(string what);
		failCount++;
		$display("FAIL %s expected done seen timeout", what);
		conclude();
	endtask

	// ****************************************
	// expected lines
	// ****************************************
	function automatic vlod_line_t grp(logic [7:0] sb, logic [7:0] t);
		vlod_line_t g;
		vlod_cat_t  sc [8] = '{CAT_INT, CAT_LOAD, CAT_STORE, CAT_LOAD,
			CAT_LDIMM, CAT_MEDIA, CAT_FLOAT, CAT_BRANCH};
		vlod_cat_t  xc [4] = '{CAT_LOAD, CAT_INT, CAT_STORE, CAT_BRANCH};
		g = '0;
		g.valid = 4'h1;
		g.kind = (sb[7:4] > SHORT_MAX_LEN || sb[3]) ? KIND_LONG : KIND_SHORT;
		// oversize encodings of any class go the vector way
		if (sb[3:0] >= CLS_VEC_BASE || sb[7:4] > LONG_MAX_LEN)
			g.kind = KIND_VECTOR;
		g.last = (g.kind != KIND_VECTOR);
		for (int k = 0; k < 4; k++) begin
			g.op[k].cat = xc[k];
			g.op[k].dualInt = (k == 1);
			g.op[k].useLoad = (k == 1);
			g.op[k].tag = t;
		end
		case ((g.kind == KIND_VECTOR) ? CLS_VEC_BASE : sb[3:0])
			CLS_CMPM: g.valid = 4'h3;
			CLS_RMW:  g.valid = 4'h7;
			CLS_RMWB: g.valid = 4'hf;
			default: begin
				if (g.kind == KIND_VECTOR) begin
					g.valid = 4'hf;
					g.op[2] = g.op[1];
					g.op[2].useLoad = 1'b0;
					g.op[3].cat = CAT_STORE;
				end else begin
					g.op[0].cat = sc[sb[2:0]];
					g.op[0].dualInt = (sb[3:0] == CLS_ADD);
				end
			end
		endcase
		return g;
	endfunction

	function automatic vlod_line_t romExp(int r, int n, logic [7:0] t);
		vlod_line_t g;
		vlod_cat_t  ev [4] = '{CAT_INT, CAT_INT, CAT_LOAD, CAT_STORE};
		vlod_cat_t  od [4] = '{CAT_MEDIA, CAT_FLOAT, CAT_INT, CAT_BRANCH};
		g.valid = 4'hf;
		g.kind = KIND_VECTOR;
		g.last = (r == n - 1);
		for (int k = 0; k < 4; k++) begin
			g.op[k].cat = r[0] ? od[k] : ev[k];
			g.op[k].dualInt = (g.op[k].cat == CAT_INT);
			g.op[k].useLoad = 1'b0;
			g.op[k].tag = t;
		end
		return g;
	endfunction

	task automatic cmpLine(vlod_line_t e, vlod_line_t g);
		check("lane mask", 32'(e.valid), 32'(g.valid));
		check("decode kind", 32'(e.kind), 32'(g.kind));
		for (int k = 0; k < 4; k++)
			if (e.valid[k])
				check("op", 32'(e.op[k]), 32'(g.op[k]));
		check("last flag", 32'(e.last), 32'(g.last));
	endtask

	// ****************************************
	// drivers
	// ****************************************
	task automatic sendLine();
		int w;
		for (int k = 0; k < 16; k++) begin
			fillValid <= 1'b1;
			fillByte  <= lineBuf[k];
			w = 0;
			do begin
				@(posedge clk);
				w++;
			end while (fillReady !== 1'b1 && w < 4000);
			if (w >= 4000)
				giveUp("fill byte");
		end
		fillValid <= 1'b0;
		@(posedge clk);
		check("fill ready low", 32'h0, 32'(fillReady));
	endtask

	task automatic runLine();
		int s;
		int i;
		int n;
		vlod_line_t a;
		vlod_line_t b;
		for (i = 0; i < 16; i++)
			lineBuf[i] = 8'($urandom);
		s = 0;
		foreach (ins[k]) begin
			lineBuf[s] = ins[k];
			s += ins[k][7:4];
		end
		s = 0;
		i = 0;
		while (i < ins.size()) begin
			a = grp(ins[i], lineBuf[(s + 1) % 16]);
			s += ins[i][7:4];
			i++;
			if (i < ins.size() && a.kind == KIND_SHORT) begin
				b = grp(ins[i], lineBuf[(s + 1) % 16]);
				if (b.kind == KIND_SHORT && s + ins[i][7:4] <= 16) begin
					n = $countones(a.valid);
					for (int r = 0; r < 2; r++)
						if (b.valid[r])
							a.op[n + r] = b.op[r];
					a.valid = a.valid | (b.valid << n);
					s += ins[i][7:4];
					i++;
				end
			end
			expQ.push_back(a);
			n = (ins[i - 1][3:0] >= CLS_VEC_BASE) ? ins[i - 1][3:0] - 9 : 1;
			if (a.kind == KIND_VECTOR)
				for (int r = 0; r < n; r++)
					expQ.push_back(romExp(r, n, a.op[0].tag));
		end
		sendLine();
	endtask

	task automatic drain(string name);
		int w;
		w = 0;
		while (expQ.size() > 0 && w < 20000) begin
			@(posedge clk);
			w++;
		end
		if (w >= 20000)
			giveUp(name);
		repeat (4) @(posedge clk);
		check("vector busy idle", 32'h0, 32'(vectorBusy));
		$display("test %s done", name);
	endtask

	task automatic runFixed(int p, int n, logic [1:0] m, string name);
		mode <= m;
		repeat (n) begin
			ins.delete();
			while (fixedIns[p] != 8'h00) begin
				ins.push_back(fixedIns[p]);
				p++;
			end
			p++;
			runLine();
		end
		if (m == 2'h2) begin
			repeat (30) @(posedge clk);
			mode <= 2'h0;
		end
		drain(name);
	endtask

	// ****************************************
	// output monitor
	// ****************************************
	always @(posedge clk) begin
		if (rst === 1'b0) begin
			if (stalled)
				check("held line", 32'h1,
					32'(schedValid === 1'b1 && heldLine === schedLine));
			if (schedValid === 1'b1 && schedReady === 1'b1) begin
				if (expQ.size() == 0)
					check("surplus line", 32'h0, 32'h1);
				else
					cmpLine(expQ.pop_front(), schedLine);
			end
			stalled = (schedValid === 1'b1 && schedReady !== 1'b1);
			heldLine = schedLine;
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		int rem;
		int ln;
		int c;
		rst = 1'b1;
		fillValid = 1'b0;
		fillByte = 8'h00;
		mode = 2'h0;
		failCount = 0;
		nCompared = 0;
		stalled = 1'b0;
		void'($urandom(31));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		check("fill ready at reset", 32'h1, 32'(fillReady));
		runFixed(0, 2, 2'h0, "short pairs");
		runFixed(13, 2, 2'h1, "long decodes");
		runFixed(19, 3, 2'h1, "vector decodes");
		runFixed(0, 1, 2'h2, "scheduler stall");
		repeat (24) begin
			mode <= 2'($urandom % 2);
			ins.delete();
			rem = 16;
			while (rem > 0) begin
				// the last one may run past the line end
				ln = 1 + $urandom % 15;
				c = $urandom % 16;
				ins.push_back({4'(ln), 4'(c)});
				rem -= ln;
			end
			runLine();
		end
		mode <= 2'h0;
		drain("random lines");
		conclude();
	end
endmodule

`default_nettype wire
